/* File: dv/lgpwm_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module lgpwm_chk (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        data_shift_clock,
  input wire logic        grayscale_clock,
  input wire logic [2:0]  cmd,
  input wire logic        serial_data_in,
  input wire logic        serial_cascade_out,
  input wire logic [15:0] channel_sink_output
);
  import lgpwm_pkg::*;
  logic        d_q;
  logic        g_q;
  logic        emit_seen;
  logic [3:0]  since_emit;
  logic [2:0]  last_cmd;
  logic [10:0] on_cnt;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // An emit code standing at a raw shift clock rise.
  assign emit_seen = data_shift_clock && !d_q
    && (cmd == CMD_FIRST_EMIT || cmd == CMD_SECOND_EMIT);

  // Previous levels of both link clocks, for edge detection.
  always_ff @(posedge clk_sys) begin
    d_q <= rst_n && data_shift_clock;
    g_q <= rst_n && grayscale_clock;
  end

  // Grayscale rises since the last emit; a coincident rise does not count.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      since_emit <= 4'hF;
    end else if (emit_seen) begin
      since_emit <= 4'h0;
    end else if (grayscale_clock && !g_q && since_emit != 4'hF) begin
      since_emit <= since_emit + 4'h1;
    end
  end

  // Last command other than a no-op that went out on the link.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      last_cmd <= CMD_NO_OPERATION;
    end else if (data_shift_clock && !d_q && cmd != CMD_NO_OPERATION) begin
      last_cmd <= cmd;
    end
  end

  // Grayscale rises seen while any sink is on; gating only lengthens it.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || channel_sink_output == 16'h0000) begin
      on_cnt <= 11'h000;
    end else if (grayscale_clock && !g_q) begin
      on_cnt <= on_cnt + 11'h001;
    end
  end

  chk_gray_rise_aligned: assert property (
    $rose(grayscale_clock) |-> $rose(data_shift_clock))
    else $error("Grayscale rise without a shift clock rise.");
  chk_gray_within_shift: assert property (
    grayscale_clock |-> data_shift_clock)
    else $error("Grayscale clock high while shift clock low.");
  chk_shift_period: assert property (
    $rose(data_shift_clock) |=> (!$rose(data_shift_clock))[*7]
      ##1 $rose(data_shift_clock))
    else $error("Shift clock period is not eight cycles.");
  chk_shift_high_time: assert property (
    $rose(data_shift_clock) |-> data_shift_clock[*4] ##1 !data_shift_clock)
    else $error("Shift clock high time is not four cycles.");
  chk_cmd_data_stable: assert property (
    data_shift_clock |-> $stable(cmd) && $stable(serial_data_in))
    else $error("Command or data moved while shift clock high.");
  chk_emit_after_disable: assert property (
    emit_seen |-> last_cmd == CMD_DISABLE)
    else $error("Emit sent without a disable before it.");
  chk_start_latency: assert property (
    $rose(|channel_sink_output) |-> since_emit == 4'h2)
    else $error("Burst did not start two grayscale clocks after emit.");
  chk_disable_stops: assert property (
    $rose(data_shift_clock) && cmd == CMD_DISABLE
      |-> ##[1:24] channel_sink_output == 16'h0000)
    else $error("Outputs still on after a disable.");
  chk_burst_length: assert property (
    on_cnt <= 11'h3FF)
    else $error("A sink stayed on longer than one burst.");
endmodule
`default_nettype wire

/* File: dv/tb_led_gray_pwm_driver.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_led_gray_pwm_driver;
  import lgpwm_pkg::*;
  logic       clk_sys        = 1'b0;
  logic       rst_n          = 1'b0;
  logic       req_valid      = 1'b0;
  lgpwm_cmd_t req_cmd        = CMD_NO_OPERATION;
  logic       req_bit        = 1'b0;
  logic       gate_grayscale = 1'b0;
  logic       req_ready;
  logic       first_switch;
  logic       second_switch;
  logic       cascade_bit;
  logic       burst_active;
  logic       dual_mode;
  logic       second_selected;
  logic       g_q            = 1'b0;
  int         failures       = 0;
  int         compares       = 0;
  int         on_t [16]      = '{default: 0};
  logic [9:0] lum [2][16];
  logic       sent_q [$];

  lgpwm_if link_if ();

  lgpwm_host i_lgpwm_host (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .link           (link_if.host),
    .req_valid      (req_valid),
    .req_cmd        (req_cmd),
    .req_bit        (req_bit),
    .req_ready      (req_ready),
    .gate_grayscale (gate_grayscale),
    .first_switch   (first_switch),
    .second_switch  (second_switch),
    .cascade_bit    (cascade_bit)
  );

  lgpwm_device i_lgpwm_device (
    .clk_sys         (clk_sys),
    .rst_n           (rst_n),
    .link            (link_if.device),
    .burst_active    (burst_active),
    .dual_mode       (dual_mode),
    .second_selected (second_selected)
  );

  lgpwm_chk i_lgpwm_chk (
    .clk_sys             (clk_sys),
    .rst_n               (rst_n),
    .data_shift_clock    (link_if.data_shift_clock),
    .grayscale_clock     (link_if.grayscale_clock),
    .cmd                 (link_if.cmd),
    .serial_data_in      (link_if.serial_data_in),
    .serial_cascade_out  (link_if.serial_cascade_out),
    .channel_sink_output (link_if.channel_sink_output)
  );

  // System clock of 8 ns.
  always #4 clk_sys = ~clk_sys;

  // On-time of each sink in raw grayscale rises, the model's unit of count.
  always @(posedge clk_sys) begin
    g_q <= link_if.grayscale_clock;
    if (link_if.grayscale_clock === 1'b1 && g_q === 1'b0) begin
      for (int i = 0; i < 16; i++) begin
        if (link_if.channel_sink_output[i] === 1'b1) on_t[i]++;
      end
    end
  end

  task automatic end_of_test();
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t ns: saw %h, expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until a slot takes it; a refused emit just waits.
  task automatic send(input lgpwm_cmd_t c, input logic b);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_cmd   <= c;
    req_bit   <= b;
    do begin
      @(posedge clk_sys);
      n++;
    end while (req_ready !== 1'b1 && n < 40);
    if (req_ready !== 1'b1) begin
      failures++;
      $display("ERROR %0t ns: request never taken", $time);
      end_of_test();
    end
  endtask

  // Idle slots go out as no-ops.
  task automatic idle(input int cycles);
    req_valid <= 1'b0;
    repeat (cycles) @(posedge clk_sys);
  endtask

  task automatic fill();
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 16; c++) lum[s][c] = 10'($urandom_range(1023));
    end
  endtask

  // Arms, shifts whole sets with channel fifteen bit nine first, captures.
  task automatic load(input int sets, input lgpwm_cmd_t mode);
    sent_q.delete();
    send(CMD_SHIFT_IN, 1'b1);
    for (int s = 0; s < sets; s++) begin
      for (int c = 15; c >= 0; c--) begin
        for (int b = 9; b >= 0; b--) begin
          send(CMD_SHIFT_IN, lum[s][c][b]);
          sent_q.push_back(lum[s][c][b]);
        end
      end
    end
    send(CMD_CAPTURE, 1'b0);
    send(mode, 1'b0);
    idle(24);
    // The oldest bit sits in the last chain stage in use by the mode.
    check(16'(cascade_bit), 16'(sent_q[0]));
  endtask

  // One burst; the gate variant stops the grayscale clock around commands.
  task automatic burst(input lgpwm_cmd_t emit, input int s,
                       input logic dual, input logic gate);
    for (int i = 0; i < 16; i++) on_t[i] = 0;
    gate_grayscale <= gate;
    send(CMD_DISABLE, 1'b0);
    send(emit, 1'b0);
    idle(16);
    gate_grayscale <= 1'b0;
    idle(40);
    if (dual) begin
      check(16'(first_switch), 16'(s == 0));
      check(16'(second_switch), 16'(s == 1));
      check(16'(second_selected), 16'(s == 1));
    end
    idle(8 * 1030);
    for (int i = 0; i < 16; i++) begin
      check(on_t[i][15:0], {6'h00, lum[s][i]});
    end
    check(16'(burst_active), 16'h0000);
    check(link_if.channel_sink_output, 16'h0000);
  endtask

  initial begin
    void'($urandom(36));
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    fill();
    lum[0][0]  = 10'h3FF;
    lum[0][1]  = 10'h001;
    lum[0][2]  = 10'h000;
    lum[0][3]  = 10'h00A;
    lum[0][15] = 10'h200;
    load(1, CMD_SINGLE_LED);
    burst(CMD_FIRST_EMIT, 0, 1'b0, 1'b0);
    // A bare emit gets a disable put in front of it by the controller.
    send(CMD_FIRST_EMIT, 1'b0);
    idle(400);
    check(16'(link_if.channel_sink_output[0]), 16'h0001);
    check(16'(link_if.channel_sink_output[3]), 16'h0000);
    // A disable lets an emit restart the running burst from count zero,
    // so the short channel comes back on.
    send(CMD_DISABLE, 1'b0);
    send(CMD_FIRST_EMIT, 1'b0);
    idle(40);
    check(16'(link_if.channel_sink_output[3]), 16'h0001);
    idle(800);
    check(16'(link_if.channel_sink_output[0]), 16'h0001);
    send(CMD_DISABLE, 1'b0);
    idle(40);
    check(link_if.channel_sink_output, 16'h0000);
    burst(CMD_FIRST_EMIT, 0, 1'b0, 1'b0);
    fill();
    lum[0][15] = 10'h155;
    load(2, CMD_DUAL_LED);
    check(16'(dual_mode), 16'h0001);
    burst(CMD_FIRST_EMIT, 0, 1'b1, 1'b0);
    burst(CMD_SECOND_EMIT, 1, 1'b1, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: hdl/lgpwm_device.sv */
`timescale 1ns/1ps
`default_nettype none
module lgpwm_device (
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  lgpwm_if.device     link,
  output logic        burst_active,
  output logic        dual_mode,
  output logic        second_selected
);
  import lgpwm_pkg::*;

  logic [5:0]            sync_q;
  logic [5:0]            sync_rise;
  logic                  data_shift_clock_rise;
  logic                  grayscale_clock_rise;
  lgpwm_cmd_t            cmd;
  logic                  din;
  logic                  armed_reg;
  logic [CHAIN_BITS-1:0] chain_reg;
  logic [CHAIN_BITS-1:0] held_reg;
  logic                  dual_reg;
  logic                  disabled_reg;
  logic                  pend_reg;
  logic                  stop_pend_reg;
  logic [1:0]            stop_lat_reg;
  logic                  pend_second_reg;
  logic [1:0]            lat_reg;
  logic                  run_reg;
  logic                  sel_second_reg;
  logic [9:0]            pwm_cnt_reg;
  logic [15:0]           sink_reg;
  logic                  sdo_reg;
  logic                  is_emit;
  logic                  busy;
  logic                  accept;
  logic                  fire;
  logic                  stop_fire;

  // All pins come from the controller's clocks, so they are synchronised
  // together; equal delay keeps command and data aligned to the clock rise.
  lgpwm_sync #(
    .W (6)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({link.data_shift_clock, link.grayscale_clock, link.cmd,
               link.serial_data_in}),
    .q       (sync_q),
    .rise    (sync_rise)
  );

  // Decoded view of the synchronised pins.
  assign data_shift_clock_rise = sync_rise[5];
  assign grayscale_clock_rise = sync_rise[4];
  assign cmd       = lgpwm_cmd_t'(sync_q[3:1]);
  assign din       = sync_q[0];

  // An emit is refused while a burst runs or is about to start, unless a
  // disable arrived since the last accepted emit.
  assign is_emit = (cmd == CMD_FIRST_EMIT) || (cmd == CMD_SECOND_EMIT);
  assign busy    = run_reg || pend_reg;
  assign accept  = data_shift_clock_rise && is_emit && (!busy || disabled_reg);

  // The pending action takes effect on the second grayscale rise.
  assign fire      = grayscale_clock_rise && pend_reg && (lat_reg == 2'h1);
  assign stop_fire = grayscale_clock_rise && stop_pend_reg && (stop_lat_reg == 2'h1);

  // The first shift-in edge only arms the chain; bits enter from the next
  // rising edge. Arming survives disable and emit so that shifting can
  // resume right after an emit pause; capture and mode commands end it.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      armed_reg <= 1'b0;
    end else if (data_shift_clock_rise) begin
      case (cmd)
        CMD_SHIFT_IN:   armed_reg <= 1'b1;
        CMD_CAPTURE:    armed_reg <= 1'b0;
        CMD_SINGLE_LED: armed_reg <= 1'b0;
        CMD_DUAL_LED:   armed_reg <= 1'b0;
        default:        armed_reg <= armed_reg;
      endcase
    end
  end

  // Serial chain: each bit enters at the bottom, so the first bit of a set
  // ends at the top, which is channel 15 bit 9.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      chain_reg <= '0;
    end else if (data_shift_clock_rise && (cmd == CMD_SHIFT_IN) && armed_reg) begin
      chain_reg <= {chain_reg[CHAIN_BITS-2:0], din};
    end
  end

  // Capture takes the whole chain, so both sets are retained and the
  // mode command may come before or after the capture.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      held_reg <= '0;
    end else if (data_shift_clock_rise && (cmd == CMD_CAPTURE)) begin
      held_reg <= chain_reg;
    end
  end

  // Time-division mode.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dual_reg <= 1'b0;
    end else if (data_shift_clock_rise && (cmd == CMD_SINGLE_LED)) begin
      dual_reg <= 1'b0;
    end else if (data_shift_clock_rise && (cmd == CMD_DUAL_LED)) begin
      dual_reg <= 1'b1;
    end
  end

  // A disable lets the next emit in even over a running burst.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      disabled_reg <= 1'b0;
    end else if (data_shift_clock_rise && (cmd == CMD_DISABLE)) begin
      disabled_reg <= 1'b1;
    end else if (accept) begin
      disabled_reg <= 1'b0;
    end
  end

  // Latency pipeline for accepted emits. A rise that coincides with the
  // latching edge does not count, so two later rises are needed.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pend_reg        <= 1'b0;
      pend_second_reg <= 1'b0;
      lat_reg         <= 2'h0;
    end else if (accept) begin
      pend_reg        <= 1'b1;
      pend_second_reg <= (cmd == CMD_SECOND_EMIT) && dual_reg;
      lat_reg         <= LATENCY;
    end else if (grayscale_clock_rise && pend_reg) begin
      lat_reg <= lat_reg - 2'h1;
      if (lat_reg == 2'h1) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // Disables have a pipeline of their own, because the controller sends the
  // emit one link period later; sharing one pipeline would lose the stop.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stop_pend_reg <= 1'b0;
      stop_lat_reg  <= 2'h0;
    end else if (data_shift_clock_rise && (cmd == CMD_DISABLE)) begin
      stop_pend_reg <= 1'b1;
      stop_lat_reg  <= LATENCY;
    end else if (grayscale_clock_rise && stop_pend_reg) begin
      stop_lat_reg <= stop_lat_reg - 2'h1;
      if (stop_lat_reg == 2'h1) begin
        stop_pend_reg <= 1'b0;
      end
    end
  end

  // One-shot burst: counts 1024 grayscale periods and then stops until the
  // next accepted emit. A disable firing stops it at once; an emit firing in the same cycle wins.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      run_reg        <= 1'b0;
      sel_second_reg <= 1'b0;
      pwm_cnt_reg    <= PWM_RESET;
    end else if (fire) begin
      run_reg        <= 1'b1;
      sel_second_reg <= pend_second_reg;
      pwm_cnt_reg    <= PWM_RESET;
    end else if (stop_fire) begin
      run_reg <= 1'b0;
    end else if (grayscale_clock_rise && run_reg) begin
      pwm_cnt_reg <= pwm_cnt_reg + 10'h001;
      if (pwm_cnt_reg == PWM_LAST) begin
        run_reg <= 1'b0;
      end
    end
  end

  // Each channel sinks while the count is below its held value. In single
  // mode the set sits in the low half of the held chain; in dual mode the
  // first-shifted set is the first LED. Held values are reused for every
  // burst until the next capture.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sink_reg <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (!run_reg) begin
          sink_reg[i] <= 1'b0;
        end else if (!dual_reg) begin
          sink_reg[i] <= pwm_cnt_reg < held_reg[i*LUM_BITS +: LUM_BITS];
        end else if (sel_second_reg) begin
          sink_reg[i] <= pwm_cnt_reg < held_reg[i*LUM_BITS +: LUM_BITS];
        end else begin
          sink_reg[i] <= pwm_cnt_reg <
                         held_reg[SET_BITS+i*LUM_BITS +: LUM_BITS];
        end
      end
    end
  end

  // Cascade output follows the last stage in use by the current mode.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sdo_reg <= 1'b0;
    end else begin
      sdo_reg <= dual_reg ? chain_reg[CHAIN_BITS-1]
                          : chain_reg[SET_BITS-1];
    end
  end

  // Outputs.
  assign link.channel_sink_output = sink_reg;
  assign link.serial_cascade_out  = sdo_reg;
  assign burst_active             = run_reg;
  assign dual_mode                = dual_reg;
  assign second_selected          = sel_second_reg;
endmodule
`default_nettype wire

/* File: hdl/lgpwm_host.sv */
`timescale 1ns/1ps
`default_nettype none
module lgpwm_host (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  lgpwm_if.host                  link,
  input  wire logic              req_valid,
  input  wire lgpwm_pkg::lgpwm_cmd_t req_cmd,
  input  wire logic              req_bit,
  output logic                   req_ready,
  input  wire logic              gate_grayscale,
  output logic                   first_switch,
  output logic                   second_switch,
  output logic                   cascade_bit
);
  import lgpwm_pkg::*;

  logic [2:0]  div_reg;
  logic        lclk_reg;
  logic        grayscale_clock_reg;
  logic        toggle;
  logic        fall_evt;
  logic        grayscale_clock_rise;
  logic        is_emit;
  logic        insert;
  lgpwm_cmd_t  send;
  lgpwm_cmd_t  cmd_reg;
  lgpwm_cmd_t  last_cmd_reg;
  logic        bit_reg;
  logic        sw_pend_reg;
  logic [1:0]  sw_val_reg;
  logic [1:0]  sw_lat_reg;
  logic [1:0]  sw_reg;
  logic [0:0]  sdo_q;

  // One divider makes both clocks, so their rises always coincide and the
  // frequency ratio is one.
  assign toggle    = div_reg == DIV_HALF_LAST;
  assign fall_evt  = toggle && lclk_reg;
  assign grayscale_clock_rise = toggle && !lclk_reg && !gate_grayscale;

  // Free-running divider for the data shift clock.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div_reg  <= 3'h0;
      lclk_reg <= 1'b0;
    end else begin
      div_reg  <= toggle ? 3'h0 : div_reg + 3'h1;
      lclk_reg <= toggle ? !lclk_reg : lclk_reg;
    end
  end

  // The grayscale clock may be held low around commands when the user
  // cannot trust the phase; releasing waits for the next aligned rise.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      grayscale_clock_reg <= 1'b0;
    end else if (toggle) begin
      grayscale_clock_reg <= !lclk_reg && !gate_grayscale;
    end
  end

  // An emit not preceded by a disable gets one inserted first; the user's
  // emit waits one slot for it.
  assign is_emit   = (req_cmd == CMD_FIRST_EMIT) ||
                     (req_cmd == CMD_SECOND_EMIT);
  assign insert    = req_valid && is_emit &&
                     (last_cmd_reg != CMD_DISABLE);
  assign send      = !req_valid ? CMD_NO_OPERATION :
                     insert ? CMD_DISABLE : req_cmd;
  assign req_ready = fall_evt && !insert;

  // Pins change on the falling edge so the device sees them settled at the
  // rise. An idle slot sends no-op, which pauses shifting but keeps arming.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd_reg      <= CMD_NO_OPERATION;
      last_cmd_reg <= CMD_NO_OPERATION;
      bit_reg      <= 1'b0;
    end else if (fall_evt) begin
      cmd_reg <= send;
      bit_reg <= req_bit;
      if (req_valid) begin
        last_cmd_reg <= send;
      end
    end
  end

  // LED switches follow the PWM start or stop, counted on the same
  // grayscale rises as the device.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sw_pend_reg <= 1'b0;
      sw_val_reg  <= 2'h0;
      sw_lat_reg  <= 2'h0;
      sw_reg      <= 2'h0;
    end else if (fall_evt && (send == CMD_DISABLE ||
                              (req_valid && is_emit))) begin
      sw_pend_reg <= 1'b1;
      sw_val_reg  <= (send == CMD_FIRST_EMIT)  ? 2'h1 :
                     (send == CMD_SECOND_EMIT) ? 2'h2 : 2'h0;
      sw_lat_reg  <= SWITCH_DELAY;
    end else if (grayscale_clock_rise && sw_pend_reg) begin
      sw_lat_reg <= sw_lat_reg - 2'h1;
      if (sw_lat_reg == 2'h1) begin
        sw_pend_reg <= 1'b0;
        sw_reg      <= sw_val_reg;
      end
    end
  end

  // The cascade pin comes from the device, so it is synchronised.
  lgpwm_sync #(
    .W (1)
  ) u_sdo_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (link.serial_cascade_out),
    .q       (sdo_q),
    .rise    ()
  );

  // Outputs.
  assign link.data_shift_clock = lclk_reg;
  assign link.grayscale_clock  = grayscale_clock_reg;
  assign link.cmd              = cmd_reg;
  assign link.serial_data_in   = bit_reg;
  assign first_switch          = sw_reg[0];
  assign second_switch         = sw_reg[1];
  assign cascade_bit           = sdo_q[0];
endmodule
`default_nettype wire

/* File: hdl/lgpwm_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface lgpwm_if;
  logic        data_shift_clock;
  logic        grayscale_clock;
  logic [2:0]  cmd;
  logic        serial_data_in;
  logic        serial_cascade_out;
  logic [15:0] channel_sink_output;

  // The controller makes both clocks, the command and the data.
  modport host (
    output data_shift_clock,
    output grayscale_clock,
    output cmd,
    output serial_data_in,
    input  serial_cascade_out,
    input  channel_sink_output
  );

  // The driver core samples everything on its own system clock.
  modport device (
    input  data_shift_clock,
    input  grayscale_clock,
    input  cmd,
    input  serial_data_in,
    output serial_cascade_out,
    output channel_sink_output
  );
endinterface
`default_nettype wire

/* File: hdl/lgpwm_pkg.sv */
package lgpwm_pkg;

  // Array geometry of the driver core.
  localparam int CHANNELS   = 16;
  localparam int LUM_BITS   = 10;
  localparam int SET_BITS   = CHANNELS * LUM_BITS;
  localparam int CHAIN_BITS = 2 * SET_BITS;

  // Last grayscale count of a one-shot burst of 1024 periods.
  localparam logic [9:0] PWM_LAST = 10'h3FF;

  // Grayscale clocks from a latched emit or disable to the PWM change.
  localparam logic [1:0] LATENCY = 2'h2;

  // The controller counts from the rise that latches the command itself.
  localparam logic [1:0] SWITCH_DELAY = 2'h3;

  // Link clocks are derived from the system clock by a divider.
  localparam int SYS_PERIOD_NS  = 8;
  localparam int LINK_PERIOD_NS = 64;
  localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / SYS_PERIOD_NS / 2;
  localparam logic [2:0] DIV_HALF_LAST = 3'(LINK_HALF_CYC - 1);

  // Reset values.
  localparam logic [9:0] PWM_RESET = 10'h000;

  // Three-bit command codes on the command pins.
  typedef enum logic [2:0] {
    CMD_NO_OPERATION = 3'b000,
    CMD_SHIFT_IN     = 3'b001,
    CMD_CAPTURE      = 3'b010,
    CMD_DISABLE      = 3'b011,
    CMD_FIRST_EMIT   = 3'b100,
    CMD_SECOND_EMIT  = 3'b101,
    CMD_SINGLE_LED   = 3'b110,
    CMD_DUAL_LED     = 3'b111
  } lgpwm_cmd_t;

endpackage

/* File: hdl/lgpwm_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module lgpwm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_d_reg;

  // Two stages; only the second stage feeds any logic.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_reg    <= '0;
      q_d_reg  <= '0;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
      q_d_reg  <= q_reg;
    end
  end

  // Edge detection looks only at settled copies.
  assign q    = q_reg;
  assign rise = q_reg & ~q_d_reg;
endmodule
`default_nettype wire
